// ===== bench/dacp_host.sv
// host controller model on the configuration port
`timescale 1ns/1ps
module dacp_host (
	input wire logic clk_i, // core clock for static pin changes
	input wire logic sdo_i, // resolved data-out wire
	output logic cs_n_o, // chip select, active low
	output logic sck_o, // port clock, still outside frames
	output logic sdi_o, // serial data
	output logic sdo_oe_o, // host drives data-out pin
	output logic sdo_o // host value on that pin
);
	localparam int HALF_NS = 16;
	// keeps the port clock edges off the core clock edges
	localparam int SKEW_NS = 5;
	// idle port at time zero
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
		sdo_oe_o = 1'b0;
		sdo_o = 1'b0;
	end

	// one frame msb first; fewer than 16 bits aborts it by raising select early
	task automatic frame(input logic [15:0] w, input int nbits, output logic [7:0] rd);
		int i;
		rd = 8'h00;
		#SKEW_NS;
		cs_n_o = 1'b0;
		for (i = 15; i > 15 - nbits; i--) begin
			sdi_o = w[i];
			#HALF_NS;
			sck_o = 1'b1;
			#HALF_NS;
			if (i >= 1 && i <= 8) rd[i - 1] = sdo_i;
			sck_o = 1'b0;
		end
		#HALF_NS;
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o; // a released line must not keep showing the last bit
		#HALF_NS;
	endtask : frame

	// static levels for parallel mode: select, clock, data, data-out
	task automatic pins(input logic [3:0] v);
		@(posedge clk_i);
		cs_n_o <= v[3];
		sck_o <= v[2];
		sdi_o <= v[1];
		sdo_o <= v[0];
		sdo_oe_o <= 1'b1;
	endtask : pins
endmodule : dacp_host

// ===== bench/dacp_top_asserts.sv
// checker watching the configuration front end at its ports
`timescale 1ns/1ps
module dacp_chk
	import dacp_pkg::*;
(
	input wire logic clk_i, // core clock
	input wire logic nrst_i, // async reset, active low
	input wire logic programming_mode_select_i, // strap
	input wire logic cs_n_i, // select or lane pin
	input wire logic sck_i, // port clock or current pin
	input wire logic sdi_i, // data or power-down pin
	input wire logic sdo_i, // resolved pin level
	input wire logic sdo_o, // pin output value
	input wire logic sdo_oe_o, // pull-low enable
	input wire logic ch1_lane_b_o, // channel 1 lane b
	input wire logic ch2_lane_b_o, // channel 2 lane b
	input wire logic lane_one_o, // one-lane mode
	input wire logic [2:0] drive_code_o, // current code
	input wire logic term_en_o, // termination
	input wire logic power_down_o, // sleep
	input wire logic dcs_en_o, // stabilizer on
	input wire logic outputs_valid_o // lock flag
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	logic lane_prev_q;
	logic [4:0] lane_age_q;
	logic [11:0] low_cnt_q;
	// a frame begun in the old lane mode may still drain, so lane age gates the lane check
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lane_prev_q <= 1'b0;
			lane_age_q <= 5'h00;
			low_cnt_q <= 12'h000;
		end else begin
			lane_prev_q <= lane_one_o;
			lane_age_q <= (lane_one_o != lane_prev_q) ? 5'h00 : lane_age_q + {4'h0, lane_age_q != 5'h1f};
			low_cnt_q <= outputs_valid_o ? 12'h000 : low_cnt_q + {11'h000, low_cnt_q != 12'hfff};
		end
	end

	chk_sdo_drain: assert property (sdo_oe_o |-> !sdo_o)
		else $error("data-out pin driven high");
	chk_sdo_frame: assert property (sdo_oe_o |-> !cs_n_i && !programming_mode_select_i)
		else $error("data-out pulled outside a serial frame");
	chk_par_lane: assert property ((programming_mode_select_i && $stable(cs_n_i))[*5] |-> lane_one_o == cs_n_i)
		else $error("lane mode does not follow select pin");
	chk_par_drive: assert property ((programming_mode_select_i && $stable(sck_i))[*5]
		|-> drive_code_o == (sck_i ? DRV_1P75 : DRV_3P5))
		else $error("drive code does not follow clock pin");
	chk_par_sleep: assert property ((programming_mode_select_i && $stable(sdi_i))[*5] |-> power_down_o == sdi_i)
		else $error("power-down does not follow data pin");
	chk_par_term: assert property ((programming_mode_select_i && $stable(sdo_i))[*5] |-> term_en_o == sdo_i)
		else $error("termination does not follow data-out pin");
	chk_par_stab: assert property (programming_mode_select_i[*5] |-> dcs_en_o)
		else $error("stabilizer off in parallel mode");
	chk_lane_b_idle: assert property (lane_one_o && lane_age_q >= 5'h14 |-> !ch1_lane_b_o && !ch2_lane_b_o)
		else $error("lane b active in one-lane mode");
	chk_relock_wait: assert property ($rose(outputs_valid_o) |-> low_cnt_q >= 12'(RELOCK_CYC - 2))
		else $error("outputs valid before relock time");
endmodule : dacp_chk

bind dacp_top dacp_chk u_dacp_chk (
	.clk_i(clk_i), .nrst_i(nrst_i), .programming_mode_select_i(programming_mode_select_i),
	.cs_n_i(cs_n_i), .sck_i(sck_i), .sdi_i(sdi_i), .sdo_i(sdo_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
	.ch1_lane_b_o(ch1_lane_b_o), .ch2_lane_b_o(ch2_lane_b_o), .lane_one_o(lane_one_o),
	.drive_code_o(drive_code_o), .term_en_o(term_en_o), .power_down_o(power_down_o),
	.dcs_en_o(dcs_en_o), .outputs_valid_o(outputs_valid_o));

// ===== bench/test_dual_adc_config_port.sv
// self-checking bench of the configuration front end
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	n_checks++; \
	if ((got) !== (exp)) begin \
		error_cnt++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
	end \
end
module test_dual_adc_config_port
	import dacp_pkg::*;
();
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic strap = 1'b0;
	logic enc = 1'b0;
	logic [25:0] conv = 26'h0000000;
	logic hold = 1'b0;
	logic cs_n, sck, sdi, h_oe, h_val, sdo_val, sdo_oe, sdo_w;
	logic lane_one, term, pdown, dcs_en, valid;
	logic bclk, fr, l1a, l1b, l2a, l2b;
	logic [2:0] drv;
	logic [1:0] nap;
	logic [7:0] rd;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed = 55520;

	always #4 clk = ~clk;
	// open-drain wire with pull-up; the host drives it only in parallel mode
	assign sdo_w = sdo_oe ? sdo_val : (h_oe ? h_val : 1'b1);

	dacp_top u_dacp_top (.clk_i(clk), .nrst_i(nrst), .programming_mode_select_i(strap),
		.cs_n_i(cs_n), .sck_i(sck), .sdi_i(sdi), .sdo_i(sdo_w), .sdo_o(sdo_val), .sdo_oe_o(sdo_oe),
		.sample_clock_pos_i(enc), .sample_clock_neg_i(~enc), .ch1_data_i(conv[11:0]),
		.ch2_data_i(conv[23:12]), .ch1_ovr_i(conv[24]), .ch2_ovr_i(conv[25]),
		.serial_bit_clock_out_o(bclk), .frame_marker_out_o(fr), .ch1_lane_a_o(l1a), .ch1_lane_b_o(l1b),
		.ch2_lane_a_o(l2a), .ch2_lane_b_o(l2b), .lane_one_o(lane_one), .drive_code_o(drv), .term_en_o(term),
		.power_down_o(pdown), .nap_o(nap), .dcs_en_o(dcs_en), .outputs_valid_o(valid));
	dacp_host u_dacp_host (.clk_i(clk), .sdo_i(sdo_w), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi),
		.sdo_oe_o(h_oe), .sdo_o(h_val));

	// sample clock at a sixteenth of the core clock, fresh words each period unless held, hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 8 == 7) enc <= ~enc;
		if (cyc % 16 == 0 && !hold) conv <= 26'($random(seed));
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end

	function automatic logic [7:0] a2_word(input logic l, input logic [2:0] d, input logic t);
		return (8'(l) << A2_LANE1_BIT) | (8'(d) << A2_DRV_LSB) | (8'(t) << A2_TERM_BIT);
	endfunction : a2_word

	function automatic logic [2:0] par_drive(input logic pin);
		return pin ? DRV_1P75 : DRV_3P5;
	endfunction : par_drive

	// expected lane word in parallel mode: data, overrange twice, two padding zeros
	function automatic logic [15:0] par_word(input logic [11:0] d, input logic ovr);
		return {d, ovr, ovr, 2'b00};
	endfunction : par_word

	// collect one frame from its marker's rise; lane b and the bit clock are gathered too
	task automatic grab(input logic one, output logic [15:0] g1, output logic [15:0] g2,
		output logic [15:0] ck, output logic bz);
		int k;
		g1 = 16'h0000;
		g2 = 16'h0000;
		ck = 16'h0000;
		bz = 1'b0;
		@(posedge clk);
		while (fr !== 1'b0) @(posedge clk);
		while (fr !== 1'b1) @(posedge clk);
		for (k = 0; k < (one ? 14 : 8); k++) begin
			g1 = one ? {g1[14:0], l1a} : {g1[13:0], l1a, l1b};
			g2 = one ? {g2[14:0], l2a} : {g2[13:0], l2a, l2b};
			ck = {ck[14:0], bclk};
			bz = bz | (one & (l1b | l2b));
			@(posedge clk);
		end
		if (one) begin
			g1 = g1 << 2;
			g2 = g2 << 2;
		end
	endtask : grab

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] dummy;
		u_dacp_host.frame({1'b0, a, d}, 16, dummy);
	endtask : wr

	task automatic rdr(input logic [6:0] a, output logic [7:0] d);
		u_dacp_host.frame({1'b1, a, 8'h00}, 16, d);
	endtask : rdr

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	initial begin
		int i;
		int t0;
		logic l, t;
		logic [2:0] dv;
		logic [3:0] v;
		logic [7:0] w;
		logic [15:0] g1, g2, ck;
		logic bz;
		repeat (20) @(posedge clk);
		`CHK(dcs_en, 1'b1)
		`CHK(sdo_oe, 1'b0)
		nrst <= 1'b1;
		t0 = cyc;
		// serial writes of the output register, each read back over the open-drain line
		for (i = 0; i < 4; i++) begin
			{l, dv, t} = (i == 0) ? 5'h1f : 5'($random(seed));
			w = a2_word(l, dv, t);
			wr(A2_OUTPUT, w);
			repeat (8) @(posedge clk);
			`CHK(term, t)
			`CHK(drv, dv)
			`CHK(lane_one, l)
			rdr(A2_OUTPUT, rd);
			`CHK(rd, w)
		end
		u_dacp_host.frame({1'b0, A2_OUTPUT, ~w}, 12, rd);
		rdr(A2_OUTPUT, rd);
		`CHK(rd, w)
		rdr(7'h05, rd);
		`CHK(rd, 8'h00)
		wr(A1_POWER, 8'h0e);
		repeat (8) @(posedge clk);
		`CHK(dcs_en, 1'b0)
		`CHK(nap, 2'h3)
		while (!valid && cyc < t0 + 4000) @(posedge clk);
		`CHK(valid, 1'b1)
		`CHK(cyc - t0 >= RELOCK_CYC, 1'b1)
		wr(A1_POWER, 8'h01);
		repeat (8) @(posedge clk);
		`CHK(pdown, 1'b1)
		`CHK(valid, 1'b0)
		$display("serial test done");
		// strap moves only while held in reset, as on a board it is tied
		nrst <= 1'b0;
		strap <= 1'b1;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		for (i = 0; i < 12; i++) begin
			v = (i < 2) ? {4{i[0]}} : (i == 2) ? 4'h8 : 4'($random(seed));
			u_dacp_host.pins(v);
			repeat (5) @(posedge clk);
			`CHK(lane_one, v[3])
			`CHK(drv, par_drive(v[2]))
			`CHK(pdown, v[1])
			`CHK(term, v[0])
			`CHK(dcs_en, 1'b1)
			`CHK(sdo_oe, 1'b0)
			// awake: freeze the words so the next whole frame carries a known sample
			if (!v[1]) begin
				hold <= 1'b1;
				repeat (24) @(posedge clk);
				grab(v[3], g1, g2, ck, bz);
				`CHK(g1, par_word(conv[11:0], conv[24]))
				`CHK(g2, par_word(conv[23:12], conv[25]))
				`CHK(ck, v[3] ? 16'h2aaa : 16'h00aa)
				`CHK(bz, 1'b0)
				hold <= 1'b0;
			end
		end
		$display("parallel test done");
		end_sim();
	end
endmodule : test_dual_adc_config_port

// ===== hdl/dacp_cfg_if.sv
// bundle between the core, the serial slave and the serializer
`timescale 1ns/1ps
interface dacp_cfg_if;
	logic [39:0] reg_img;
	logic wr_tgl;
	logic [15:0] ch1_word;
	logic [15:0] ch2_word;
	logic load;
	logic lane_one;
	logic out_en;
	logic ch1_on;
	logic ch2_on;

	modport spi_mp (output reg_img, output wr_tgl);
	modport core_mp (input reg_img, input wr_tgl, output ch1_word, output ch2_word, output load,
		output lane_one, output out_en, output ch1_on, output ch2_on);
	modport ser_mp (input ch1_word, input ch2_word, input load, input lane_one, input out_en,
		input ch1_on, input ch2_on);
endinterface : dacp_cfg_if

// ===== hdl/dacp_pkg.sv
// shared constants of the converter configuration port
package dacp_pkg;
	// clock and timing
	localparam int CLK_MHZ = 125;
	localparam int RELOCK_US = 25;
	localparam int RELOCK_CYC = RELOCK_US * CLK_MHZ;
	localparam int STOP_CYC = 48;
	localparam int PER_TOL = 2;

	// serial frame: read flag, 7 address bits, 8 data bits
	localparam logic [3:0] ADDR_LAST = 4'h7;
	localparam logic [3:0] FRAME_LAST = 4'hf;
	localparam int NREG = 5;

	// mode control register offsets
	localparam logic [6:0] A0_RESET = 7'h00;
	localparam logic [6:0] A1_POWER = 7'h01;
	localparam logic [6:0] A2_OUTPUT = 7'h02;
	localparam logic [6:0] A3_TEST_HI = 7'h03;
	localparam logic [6:0] A4_TEST_LO = 7'h04;

	// field positions
	localparam int A0_SWRST_BIT = 7;
	localparam int A1_SLEEP_BIT = 0;
	localparam int A1_NAP1_BIT = 1;
	localparam int A1_NAP2_BIT = 2;
	localparam int A1_DCSOFF_BIT = 3;
	localparam int A1_TWOS_BIT = 4;
	localparam int A1_RAND_BIT = 5;
	localparam int A2_TERM_BIT = 0;
	localparam int A2_OUTDIS_BIT = 1;
	localparam int A2_DRV_LSB = 2;
	localparam int A2_LANE1_BIT = 5;
	localparam int A3_TEST_BIT = 7;

	// reset values
	localparam logic [7:0] REG_RST = 8'h00;

	// drive current codes
	localparam logic [2:0] DRV_3P5 = 3'h0;
	localparam logic [2:0] DRV_1P75 = 3'h1;

	// frame lengths in bit periods
	localparam logic [3:0] TWO_LANE_PERIODS = 4'h8;
	localparam logic [3:0] ONE_LANE_PERIODS = 4'he;

	typedef enum logic [2:0] {
		DACP_LK_IDLE = 3'b001,
		DACP_LK_WAIT = 3'b010,
		DACP_LK_LOCKED = 3'b100
	} dacp_lock_t;
endpackage : dacp_pkg

// ===== hdl/dacp_serializer.sv
// per-channel lane serializer with bit clock and frame marker
`timescale 1ns/1ps
module dacp_serializer
	import dacp_pkg::*;
(
	input wire logic clk_i, // core clock
	input wire logic nrst_i, // async reset, active low
	dacp_cfg_if.ser_mp cfg, // words and lane setup
	output logic bit_clk_o, // serial bit clock out
	output logic frame_o, // frame marker out
	output logic ch1_a_o, // channel 1 lane a
	output logic ch1_b_o, // channel 1 lane b
	output logic ch2_a_o, // channel 2 lane a
	output logic ch2_b_o // channel 2 lane b
);
	logic [15:0] w1_q;
	logic [15:0] w2_q;
	logic [3:0] idx_q;
	logic [3:0] last_w;
	logic busy_q;
	logic [3:0] sel_a;
	logic [3:0] sel_b;

	assign last_w = cfg.lane_one ? ONE_LANE_PERIODS : TWO_LANE_PERIODS;
	// two lanes take bit pairs, one lane walks one bit at a time from bit 15 down to bit 2
	assign sel_a = cfg.lane_one ? 4'hf - idx_q : 4'hf - {idx_q[2:0], 1'b0}; // [R09] [R13]
	assign sel_b = 4'he - {idx_q[2:0], 1'b0};

	// a new sample restarts the frame; both words are taken together
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			w1_q <= 16'h0000;
			w2_q <= 16'h0000;
			idx_q <= 4'h0;
			busy_q <= 1'b0;
			bit_clk_o <= 1'b0;
			frame_o <= 1'b0;
			{ch1_a_o, ch1_b_o, ch2_a_o, ch2_b_o} <= 4'h0;
		end else begin
			if (cfg.load) begin
				w1_q <= cfg.ch1_word;
				w2_q <= cfg.ch2_word;
				idx_q <= 4'h0;
				busy_q <= cfg.out_en;
			end else if (busy_q) begin
				// stop after the last bit period, so the marker rises only for a new sample
				idx_q <= idx_q + 4'h1;
				busy_q <= (idx_q != last_w - 4'h1);
			end
			bit_clk_o <= busy_q & ~bit_clk_o;
			frame_o <= busy_q && (idx_q < (last_w >> 1));
			ch1_a_o <= busy_q & cfg.ch1_on & w1_q[sel_a];
			ch2_a_o <= busy_q & cfg.ch2_on & w2_q[sel_a];
			ch1_b_o <= busy_q & cfg.ch1_on & ~cfg.lane_one & w1_q[sel_b]; // [R09]
			ch2_b_o <= busy_q & cfg.ch2_on & ~cfg.lane_one & w2_q[sel_b];
		end
	end
endmodule : dacp_serializer

// ===== hdl/dacp_spi_slave.sv
// serial slave on the port clock holding the mode control registers
`timescale 1ns/1ps
module dacp_spi_slave
	import dacp_pkg::*;
(
	input wire logic sck_i, // port clock
	input wire logic nrst_i, // async reset, active low
	input wire logic cs_n_i, // chip select, active low
	input wire logic par_i, // strap, high in parallel mode
	input wire logic sdi_i, // serial data in
	output logic rd_drive_o, // readback bit is being presented
	output logic rd_bit_o, // readback bit value
	dacp_cfg_if.spi_mp cfg // register image out
);
	logic [3:0] cnt_q;
	logic [6:0] sh_q;
	logic rw_q;
	logic [7:0] rd_q;
	logic [7:0] regs_q [NREG];
	logic wr_tgl_q;
	logic frame_rst_n;
	logic [6:0] addr_w;
	logic [7:0] wdata_w;
	logic do_write;

	// the frame ends on chip select itself, since the port clock stops between frames
	assign frame_rst_n = nrst_i & ~cs_n_i & ~par_i; // [R14] [R06]
	assign addr_w = {sh_q[5:0], sdi_i};
	assign wdata_w = {sh_q[6:0], sdi_i};
	assign do_write = (cnt_q == FRAME_LAST) && !rw_q;

	// shift and count on the rising port clock edge
	always_ff @(posedge sck_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			cnt_q <= 4'h0;
			sh_q <= 7'h00;
			rw_q <= 1'b0;
			rd_q <= 8'hff;
			rd_drive_o <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
			sh_q <= {sh_q[5:0], sdi_i}; // [R01]
			if (cnt_q == 4'h0) rw_q <= sdi_i;
			if (cnt_q == ADDR_LAST) begin
				rd_q <= (addr_w < 7'(NREG)) ? regs_q[addr_w[2:0]] : 8'h00; // [R03]
				rd_drive_o <= rw_q;
			end else begin
				rd_q <= {rd_q[6:0], 1'b1};
			end
		end
	end

	// register store; address latched from the shifter on the eighth edge
	logic [6:0] waddr_q;
	always_ff @(posedge sck_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < NREG; i++) regs_q[i] <= REG_RST;
			waddr_q <= 7'h00;
			wr_tgl_q <= 1'b0;
		end else if (!cs_n_i && !par_i) begin
			if (cnt_q == ADDR_LAST) waddr_q <= addr_w;
			if (do_write) begin
				wr_tgl_q <= ~wr_tgl_q;
				if (waddr_q == A0_RESET && wdata_w[A0_SWRST_BIT]) begin
					for (int i = 0; i < NREG; i++) regs_q[i] <= REG_RST;
				end else if (waddr_q < 7'(NREG)) begin
					regs_q[waddr_q[2:0]] <= wdata_w; // [R01]
				end
			end
		end
	end

	assign rd_bit_o = rd_q[7];
	assign cfg.wr_tgl = wr_tgl_q;
	assign cfg.reg_img = {regs_q[4], regs_q[3], regs_q[2], regs_q[1], regs_q[0]};
endmodule : dacp_spi_slave

// ===== hdl/dacp_top.sv
// configuration front end of the two-channel converter
//
// What this block does
// (R01) serial mode: SDI captured on rising SCK
// (R02) parallel mode: SDI level powers down part
// (R03) serial mode: registers read back on SDO
// (R04) SDO only pulls low, never drives high
// (R05) parallel mode: SDO level enables internal termination
// (R06) strap low: four pins form serial port
// (R07) strap high: four pins are static inputs
// (R08) strap is tied, never switched by logic
// (R09) two lanes per channel, or lane A only
// (R10) both channels sampled on same clock edge
// (R11) output untrusted for 25 us after clock change
// (R12) stabilizer always on in parallel mode
// (R13) two bits or one bit per period
// (R14) shifting only while chip select is low
// (R15) parallel: CS low two-lane, high one-lane
// (R16) parallel: SCK picks 3.5 or 1.75 mA
// (R17) parallel settings follow pins continuously
`timescale 1ns/1ps
module dacp_top
	import dacp_pkg::*;
(
	input wire logic clk_i, // core clock, 125 MHz
	input wire logic nrst_i, // async reset, active low
	input wire logic programming_mode_select_i, // strap, high selects parallel mode
	input wire logic cs_n_i, // chip select or lane select pin
	input wire logic sck_i, // port clock or current select pin
	input wire logic sdi_i, // serial data or power-down pin
	input wire logic sdo_i, // pin level, termination select in parallel mode
	output logic sdo_o, // pin output value, always low
	output logic sdo_oe_o, // high while pulling the pin low
	input wire logic sample_clock_pos_i, // sample clock, true side
	input wire logic sample_clock_neg_i, // sample clock, complement side
	input wire logic [11:0] ch1_data_i, // channel 1 conversion result
	input wire logic [11:0] ch2_data_i, // channel 2 conversion result
	input wire logic ch1_ovr_i, // channel 1 overrange
	input wire logic ch2_ovr_i, // channel 2 overrange
	output logic serial_bit_clock_out_o, // bit clock out
	output logic frame_marker_out_o, // frame marker out
	output logic ch1_lane_a_o, // channel 1 lane a
	output logic ch1_lane_b_o, // channel 1 lane b
	output logic ch2_lane_a_o, // channel 2 lane a
	output logic ch2_lane_b_o, // channel 2 lane b
	output logic lane_one_o, // one-lane mode active
	output logic [2:0] drive_code_o, // output current code
	output logic term_en_o, // internal termination enabled
	output logic power_down_o, // whole part asleep
	output logic [1:0] nap_o, // per-channel nap
	output logic dcs_en_o, // duty-cycle stabilizer enabled
	output logic outputs_valid_o // output clock locked, data trusted
);
	dacp_cfg_if cfg ();

	// two-flop synchronisers for the strap, port and sample clock pins; conversion data and overrange are read directly
	logic [1:0] par_s_q;
	logic [1:0] cs_s_q;
	logic [1:0] sck_s_q;
	logic [1:0] sdi_s_q;
	logic [1:0] sdo_s_q;
	logic [1:0] encp_s_q;
	logic [1:0] encn_s_q;
	logic [1:0] wr_s_q;
	logic par_w;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			par_s_q <= 2'b00;
			cs_s_q <= 2'b11;
			sck_s_q <= 2'b00;
			sdi_s_q <= 2'b00;
			sdo_s_q <= 2'b00;
			encp_s_q <= 2'b00;
			encn_s_q <= 2'b00;
			wr_s_q <= 2'b00;
		end else begin
			par_s_q <= {par_s_q[0], programming_mode_select_i};
			cs_s_q <= {cs_s_q[0], cs_n_i};
			sck_s_q <= {sck_s_q[0], sck_i};
			sdi_s_q <= {sdi_s_q[0], sdi_i};
			sdo_s_q <= {sdo_s_q[0], sdo_i};
			encp_s_q <= {encp_s_q[0], sample_clock_pos_i};
			encn_s_q <= {encn_s_q[0], sample_clock_neg_i};
			wr_s_q <= {wr_s_q[0], cfg.wr_tgl};
		end
	end

	// the strap is expected static; it is only synchronised, not filtered
	assign par_w = par_s_q[1]; // [R08]

	// serial slave lives on the port clock
	logic rd_drive;
	logic rd_bit;

	dacp_spi_slave u_spi (
		.sck_i(sck_i),
		.nrst_i(nrst_i),
		.cs_n_i(cs_n_i),
		.par_i(programming_mode_select_i),
		.sdi_i(sdi_i),
		.rd_drive_o(rd_drive),
		.rd_bit_o(rd_bit),
		.cfg(cfg)
	);

	// open-drain readback: pull low for a zero, release for a one; the pin is
	// never driven high, so a host that skips readback needs no pull-up at all
	// the strap term keeps a stale frame from pulling the pin in parallel mode
	assign sdo_o = 1'b0; // [R04]
	assign sdo_oe_o = rd_drive & ~rd_bit & ~cs_n_i & ~par_w; // [R03] [R04] [R05]

	// register image copy: the toggle marks a finished write, the image is
	// stable for many port clocks afterwards, so a plain copy is safe
	logic [39:0] img_q;
	logic wr_seen_q;
	logic wr_evt;

	assign wr_evt = wr_s_q[1] ^ wr_seen_q;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			img_q <= {5{REG_RST}};
			wr_seen_q <= 1'b0;
		end else begin
			wr_seen_q <= wr_s_q[1];
			if (wr_evt) img_q <= cfg.reg_img;
		end
	end

	// field decode of the serial register image
	logic [7:0] a1_w;
	logic [7:0] a2_w;
	logic [7:0] a3_w;
	logic [7:0] a4_w;

	assign a1_w = img_q[15:8];
	assign a2_w = img_q[23:16];
	assign a3_w = img_q[31:24];
	assign a4_w = img_q[39:32];

	// effective settings; parallel mode follows the pin levels every cycle
	// parallel mode has no nap and no output disable, so both fall back to idle
	logic lane_one_w;
	logic [2:0] drive_w;
	logic term_w;
	logic sleep_w;
	logic [1:0] nap_w;
	logic dcs_w;
	logic out_dis_w;
	logic twos_w;
	logic rand_w;
	logic test_w;

	assign lane_one_w = par_w ? cs_s_q[1] : a2_w[A2_LANE1_BIT]; // [R15] [R17] [R07]
	assign drive_w = par_w ? (sck_s_q[1] ? DRV_1P75 : DRV_3P5) : a2_w[A2_DRV_LSB +: 3]; // [R16] [R17]
	assign term_w = par_w ? sdo_s_q[1] : a2_w[A2_TERM_BIT]; // [R05] [R17]
	assign sleep_w = par_w ? sdi_s_q[1] : a1_w[A1_SLEEP_BIT]; // [R02] [R17]
	assign nap_w = par_w ? 2'b00 : {a1_w[A1_NAP2_BIT], a1_w[A1_NAP1_BIT]}; // [R06]
	assign dcs_w = par_w ? 1'b1 : ~a1_w[A1_DCSOFF_BIT]; // [R12]
	assign out_dis_w = par_w ? 1'b0 : a2_w[A2_OUTDIS_BIT];
	assign twos_w = ~par_w & a1_w[A1_TWOS_BIT];
	assign rand_w = ~par_w & a1_w[A1_RAND_BIT];
	assign test_w = ~par_w & a3_w[A3_TEST_BIT];

	// registered control outputs
	// a register here keeps synchroniser settling and decode glitches off the pins
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lane_one_o <= 1'b0;
			drive_code_o <= DRV_3P5;
			term_en_o <= 1'b0;
			power_down_o <= 1'b0;
			nap_o <= 2'b00;
			dcs_en_o <= 1'b1;
		end else begin
			lane_one_o <= lane_one_w;
			drive_code_o <= drive_w;
			term_en_o <= term_w;
			power_down_o <= sleep_w;
			nap_o <= nap_w;
			dcs_en_o <= dcs_w;
		end
	end

	// sample clock: differential level, rising edge starts a conversion
	logic enc_lvl_w;
	logic enc_prev_q;
	logic enc_rise;

	assign enc_lvl_w = encp_s_q[1] & ~encn_s_q[1];
	assign enc_rise = enc_lvl_w & ~enc_prev_q;

	// output word formatting; the test pattern overrides two's complement and
	// the randomizer, which xors every bit above the lsb with the lsb
	function automatic logic [15:0] fmt_word(input logic [11:0] d, input logic ovr, input logic tw,
		input logic rn, input logic tp, input logic [13:0] pat, input logic one);
		logic [11:0] v;
		logic [13:0] w;
		v = tw ? {~d[11], d[10:0]} : d;
		v = rn ? {v[11:1] ^ {11{v[0]}}, v[0]} : v;
		w = tp ? pat : {v, ovr, ovr};
		fmt_word = one ? {w, 2'b00} : {w, 2'b00};
	endfunction : fmt_word

	// the test pattern spans the low six bits of one register and all of the next
	logic [13:0] pat_w;
	assign pat_w = {a3_w[5:0], a4_w};

	// both channels captured on one sample edge through one shared path
	logic [15:0] w1_q;
	logic [15:0] w2_q;
	logic load_q;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			enc_prev_q <= 1'b0;
			w1_q <= 16'h0000;
			w2_q <= 16'h0000;
			load_q <= 1'b0;
		end else begin
			enc_prev_q <= enc_lvl_w;
			load_q <= enc_rise;
			if (enc_rise) begin
				w1_q <= fmt_word(ch1_data_i, ch1_ovr_i, twos_w, rand_w, test_w, pat_w, lane_one_w); // [R10]
				w2_q <= fmt_word(ch2_data_i, ch2_ovr_i, twos_w, rand_w, test_w, pat_w, lane_one_w); // [R10]
			end
		end
	end

	// relock watch: a stopped clock or a changed period restarts the wait
	logic [5:0] per_cnt_q;
	logic [5:0] per_last_q;
	logic [11:0] lock_cnt_q;
	dacp_lock_t lk_q;
	dacp_lock_t lk_d;
	logic stopped_w;
	logic per_jump_w;
	logic restart_w;

	// the period counter saturates, so a stopped clock stays flagged until it returns
	assign stopped_w = per_cnt_q >= 6'(STOP_CYC);
	assign per_jump_w = enc_rise && ((per_cnt_q > per_last_q + 6'(PER_TOL)) ||
		(per_last_q > per_cnt_q + 6'(PER_TOL)));
	assign restart_w = stopped_w | per_jump_w | sleep_w;

	// sleep counts as a restart, since the output clock is off while asleep
	always_comb begin
		lk_d = lk_q;
		case (lk_q)
			DACP_LK_IDLE: begin
				if (enc_rise && !sleep_w) lk_d = DACP_LK_WAIT;
			end
			DACP_LK_WAIT: begin
				if (restart_w) lk_d = DACP_LK_IDLE;
				else if (lock_cnt_q == 12'(RELOCK_CYC - 1)) lk_d = DACP_LK_LOCKED; // [R11]
			end
			DACP_LK_LOCKED: begin
				if (restart_w) lk_d = DACP_LK_IDLE; // [R11]
			end
			default: lk_d = DACP_LK_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lk_q <= DACP_LK_IDLE;
			per_cnt_q <= 6'h00;
			per_last_q <= 6'h00;
			lock_cnt_q <= 12'h000;
		end else begin
			lk_q <= lk_d;
			if (enc_rise) per_cnt_q <= 6'h01;
			else if (!stopped_w) per_cnt_q <= per_cnt_q + 6'h01;
			if (enc_rise) per_last_q <= per_cnt_q;
			lock_cnt_q <= (lk_q == DACP_LK_WAIT) ? lock_cnt_q + 12'h001 : 12'h000;
		end
	end

	assign outputs_valid_o = (lk_q == DACP_LK_LOCKED); // [R11]

	// serializer controls; a napped channel holds its lanes low
	assign cfg.ch1_word = w1_q;
	assign cfg.ch2_word = w2_q;
	assign cfg.load = load_q;
	assign cfg.lane_one = lane_one_w; // [R09] [R13]
	assign cfg.out_en = ~out_dis_w & ~sleep_w;
	assign cfg.ch1_on = ~nap_w[0];
	assign cfg.ch2_on = ~nap_w[1];

	// lane serializer; limitation: one bit per core clock, so a frame is
	// cut short when the sample clock outruns it
	dacp_serializer u_ser (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.cfg(cfg),
		.bit_clk_o(serial_bit_clock_out_o),
		.frame_o(frame_marker_out_o),
		.ch1_a_o(ch1_lane_a_o),
		.ch1_b_o(ch1_lane_b_o),
		.ch2_a_o(ch2_lane_a_o),
		.ch2_b_o(ch2_lane_b_o)
	);
endmodule : dacp_top
